// ===== inc/asc_pkg.sv
// Constants and carrier types of the association and scan control block.
// Assumes one 20 MHz clock and a synchronous, active-low reset.
//
// Contract
// - mask bit n scans channel 0x0B plus n
// - standard variant scans up to sixteen channels
// - high-power variant mask limited to 0x3FFE
// - exponent zero to fifteen, resets to four
// - scan time is channels times 2^exp times 15.36ms
// - end node times its join scan by exponent
// - coordinator times active and energy scans alike
// - option bit 0 accepts any network identifier
// - option bit 1 accepts any channel
// - option bit 2 retries joining until success
// - beacon networks always join regardless of bit
// - option bit 3 polls coordinator after pin wake
// - end node options four bits, reset zero
// - coordinator bit 0 scans, replaces conflicting identifier
// - coordinator bit 0 clear keeps configured identifier
// - coordinator bit 1 energy scans for free channel
// - coordinator bit 2 accepts or refuses joins
// - coordinator options three bits, reset zero
// - role setting selects end node or coordinator
// - read-only join status, 0xFF busy, 0x01 timeout
`default_nettype none

package asc_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int BASE_PERIOD_NS = 15360000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int BASE_CYCLES = BASE_PERIOD_NS / CLK_PERIOD_NS;

  // ----------------------------------------
  // Register selects and layouts
  // ----------------------------------------
  localparam logic [2:0] SEL_CHAN_MASK = 3'h0;
  localparam logic [2:0] SEL_SCAN_EXP = 3'h1;
  localparam logic [2:0] SEL_END_OPT = 3'h2;
  localparam logic [2:0] SEL_COORD_OPT = 3'h3;
  localparam logic [2:0] SEL_JOIN_STATUS = 3'h4;
  localparam logic [15:0] MASK_RST = 16'h1FFE;
  localparam logic [15:0] MASK_HP_LEGAL = 16'h3FFE;
  localparam logic [3:0] EXP_RST = 4'h4;
  localparam logic [3:0] END_OPT_RST = 4'h0;
  localparam logic [2:0] COORD_OPT_RST = 3'h0;
  localparam logic [7:0] CHAN_BASE = 8'h0B;
  localparam int OPT_ANY_NET = 0;
  localparam int OPT_ANY_CHAN = 1;
  localparam int OPT_AUTO_JOIN = 2;
  localparam int OPT_POLL_WAKE = 3;
  localparam int OPT_ACCEPT = 2;

  // ----------------------------------------
  // Join status codes
  // ----------------------------------------
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_SCAN_TIMEOUT = 8'h01;
  localparam logic [7:0] ST_NO_PERMIT = 8'h03;
  localparam logic [7:0] ST_NET_MISMATCH = 8'h05;
  localparam logic [7:0] ST_CHAN_MISMATCH = 8'h06;
  localparam logic [7:0] ST_ENERGY_TIMEOUT = 8'h07;
  localparam logic [7:0] ST_JOIN_TIMEOUT = 8'h0C;
  localparam logic [7:0] ST_BUSY = 8'hFF;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    FSM_IDLE = 3'b000,
    FSM_ASCAN = 3'b001,
    FSM_ESCAN = 3'b010,
    FSM_JOIN_WAIT = 3'b011,
    FSM_RUN = 3'b100
  } asc_fsm_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] sel;
    logic [15:0] wdata;
  } asc_cmd_type;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } asc_rsp_type;

  typedef struct packed {
    logic valid;
    logic pan_match;
    logic permit;
  } asc_beacon_type;

  typedef struct packed {
    logic valid;
    logic [7:0] level;
  } asc_energy_type;

  typedef struct packed {
    asc_fsm_type fsm;
    logic [15:0] mask;
    logic [3:0] exp;
    logic [3:0] end_opt;
    logic [2:0] coord_opt;
    logic [7:0] status;
    logic [3:0] idx;
    logic [18:0] cyc;
    logic [15:0] per;
    logic fail_seen;
    logic [7:0] fail_code;
    logic pan_conflict;
    logic best_ok;
    logic [7:0] best_lvl;
    logic [3:0] best_idx;
    logic [7:0] op_chan;
    logic joined;
    logic coord_up;
    logic join_req;
    logic poll_req;
    asc_rsp_type rsp;
  } asc_state_type;

endpackage : asc_pkg

`default_nettype wire

// ===== logic/asc_core.sv
// Association and scan control: option registers, scan timer and join flow.
// Assumes synchronous inputs, a radio that reports beacons and energy levels
// for the channel on SCAN_CHANNEL, and a MAC that performs the join request.
`default_nettype none

module asc_core #(
  parameter int BASE_CYCLES = asc_pkg::BASE_CYCLES
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Configuration command port
  input wire asc_pkg::asc_cmd_type CMD,
  output asc_pkg::asc_rsp_type RSP,
  // Node settings
  input wire logic COORD_ROLE,
  input wire logic HIGH_POWER,
  input wire logic BEACON_NET,
  input wire logic [7:0] OPERATING_CHANNEL,
  // Control events
  input wire logic START,
  input wire logic PIN_WAKE,
  input wire logic JOIN_DONE,
  input wire logic JOIN_FAIL,
  // Radio reports
  input wire asc_pkg::asc_beacon_type BEACON,
  input wire asc_pkg::asc_energy_type ENERGY,
  // Scan and network outputs
  output logic SCAN_ON,
  output logic SCAN_ENERGY,
  output logic [7:0] SCAN_CHANNEL,
  output logic [7:0] OPER_CHANNEL,
  output logic PAN_REPLACE,
  output logic JOIN_REQ,
  output logic POLL_REQ,
  output logic JOINED,
  output logic COORD_UP,
  output logic ACCEPT_JOINS
);

  asc_pkg::asc_state_type s_r;
  asc_pkg::asc_state_type s_nxt;
  logic [15:0] mask_eff;
  logic cyc_last;
  logic per_last;
  logic [4:0] first_ch;
  logic [4:0] next_ch;
  logic scan_step;
  logic scan_end;
  logic pan_ok;
  logic chan_ok;
  logic [7:0] cur_chan;

  // ----------------------------------------
  // Channel search
  // ----------------------------------------
  // Lowest enabled channel at or above from; bit 4 set when one exists
  function automatic logic [4:0] find_ch(input logic [15:0] m, input logic [4:0] from);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 15; i >= 0; i--) begin
      if (m[i] && (5'(i) >= from)) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction : find_ch

  // ----------------------------------------
  // Scan timer
  // ----------------------------------------
  // High-power part masks off any outer channels software asks for; an empty result still scans 0x0B
  assign mask_eff = HIGH_POWER ? (s_r.mask & asc_pkg::MASK_HP_LEGAL) : s_r.mask;
  assign cur_chan = asc_pkg::CHAN_BASE + {4'h0, s_r.idx};
  assign cyc_last = (s_r.cyc == 19'(BASE_CYCLES - 1));
  assign per_last = (s_r.per == ((16'h1 << s_r.exp) - 16'h1));
  assign first_ch = find_ch(mask_eff, 5'h00);
  assign next_ch = find_ch(mask_eff, {1'b0, s_r.idx} + 5'h01);
  assign scan_step = cyc_last && per_last;
  // An empty mask ends the scan at once rather than hanging
  assign scan_end = (mask_eff == 16'h0000) || (scan_step && !next_ch[4]);
  assign pan_ok = s_r.end_opt[asc_pkg::OPT_ANY_NET] || BEACON.pan_match;
  assign chan_ok = s_r.end_opt[asc_pkg::OPT_ANY_CHAN]
                   || (cur_chan == OPERATING_CHANNEL);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.join_req = 1'b0;
    s_nxt.poll_req = 1'b0;
    s_nxt.rsp.valid = 1'b0;
    // Register access
    if (CMD.wr) begin
      case (CMD.sel)
        asc_pkg::SEL_CHAN_MASK: s_nxt.mask = HIGH_POWER ? (CMD.wdata & asc_pkg::MASK_HP_LEGAL)
                                                        : CMD.wdata;
        asc_pkg::SEL_SCAN_EXP: s_nxt.exp = CMD.wdata[3:0];
        asc_pkg::SEL_END_OPT: s_nxt.end_opt = CMD.wdata[3:0];
        asc_pkg::SEL_COORD_OPT: s_nxt.coord_opt = CMD.wdata[2:0];
        default: s_nxt.mask = s_r.mask; // Status is read-only
      endcase
    end
    if (CMD.rd) begin
      s_nxt.rsp.valid = 1'b1;
      case (CMD.sel)
        asc_pkg::SEL_CHAN_MASK: s_nxt.rsp.data = s_r.mask;
        asc_pkg::SEL_SCAN_EXP: s_nxt.rsp.data = {12'h000, s_r.exp};
        asc_pkg::SEL_END_OPT: s_nxt.rsp.data = {12'h000, s_r.end_opt};
        asc_pkg::SEL_COORD_OPT: s_nxt.rsp.data = {13'h0000, s_r.coord_opt};
        asc_pkg::SEL_JOIN_STATUS: s_nxt.rsp.data = {8'h00, s_r.status};
        default: s_nxt.rsp.data = 16'h0000;
      endcase
    end
    // Timer advances only while a scan runs
    if ((s_r.fsm == asc_pkg::FSM_ASCAN) || (s_r.fsm == asc_pkg::FSM_ESCAN)) begin
      s_nxt.cyc = cyc_last ? 19'h00000 : s_r.cyc + 19'h00001;
      if (cyc_last) begin
        s_nxt.per = per_last ? 16'h0000 : s_r.per + 16'h0001;
      end
      if (scan_step && next_ch[4]) begin
        s_nxt.idx = next_ch[3:0];
        s_nxt.cyc = 19'h00000;
        s_nxt.per = 16'h0000;
      end
    end
    case (s_r.fsm)
      asc_pkg::FSM_ASCAN: begin
        if (BEACON.valid && !COORD_ROLE) begin
          if (pan_ok && chan_ok && BEACON.permit) begin
            s_nxt.fsm = asc_pkg::FSM_JOIN_WAIT;
            s_nxt.join_req = 1'b1;
          end else begin
            s_nxt.fail_seen = 1'b1;
            s_nxt.fail_code = !pan_ok ? asc_pkg::ST_NET_MISMATCH :
                              (!chan_ok ? asc_pkg::ST_CHAN_MISMATCH : asc_pkg::ST_NO_PERMIT);
          end
        end else if (BEACON.valid && BEACON.pan_match) begin
          s_nxt.pan_conflict = 1'b1;
        end
        if (scan_end && !(BEACON.valid && !COORD_ROLE && pan_ok && chan_ok && BEACON.permit)) begin
          s_nxt.cyc = 19'h00000;
          s_nxt.per = 16'h0000;
          s_nxt.idx = first_ch[3:0];
          if (COORD_ROLE) begin
            if (s_r.coord_opt[1]) begin
              s_nxt.fsm = asc_pkg::FSM_ESCAN;
            end else begin
              s_nxt.fsm = asc_pkg::FSM_RUN;
              s_nxt.op_chan = OPERATING_CHANNEL;
              s_nxt.coord_up = 1'b1;
              s_nxt.status = asc_pkg::ST_OK;
            end
          end else begin
            s_nxt.status = s_r.fail_seen ? s_r.fail_code : asc_pkg::ST_SCAN_TIMEOUT;
            s_nxt.fail_seen = 1'b0;
            // Retry for as long as joining is still wanted
            if (!(s_r.end_opt[asc_pkg::OPT_AUTO_JOIN] || BEACON_NET)) begin
              s_nxt.fsm = asc_pkg::FSM_IDLE;
            end
          end
        end
      end
      asc_pkg::FSM_ESCAN: begin
        if (ENERGY.valid && (!s_r.best_ok || (ENERGY.level < s_r.best_lvl))) begin
          s_nxt.best_ok = 1'b1;
          s_nxt.best_lvl = ENERGY.level;
          s_nxt.best_idx = s_r.idx;
        end
        if (scan_end) begin
          s_nxt.fsm = asc_pkg::FSM_RUN;
          s_nxt.coord_up = 1'b1;
          s_nxt.op_chan = s_r.best_ok ? (asc_pkg::CHAN_BASE + {4'h0, s_r.best_idx})
                                      : OPERATING_CHANNEL;
          s_nxt.status = s_r.best_ok ? asc_pkg::ST_OK : asc_pkg::ST_ENERGY_TIMEOUT;
        end
      end
      asc_pkg::FSM_JOIN_WAIT: begin
        if (JOIN_DONE) begin
          s_nxt.fsm = asc_pkg::FSM_RUN;
          s_nxt.joined = 1'b1;
          s_nxt.op_chan = cur_chan;
          s_nxt.status = asc_pkg::ST_OK;
        end else if (JOIN_FAIL) begin
          s_nxt.status = asc_pkg::ST_JOIN_TIMEOUT;
          s_nxt.fsm = (s_r.end_opt[asc_pkg::OPT_AUTO_JOIN] || BEACON_NET) ?
                      asc_pkg::FSM_ASCAN : asc_pkg::FSM_IDLE;
          s_nxt.cyc = 19'h00000;
          s_nxt.per = 16'h0000;
          s_nxt.idx = first_ch[3:0];
        end
      end
      asc_pkg::FSM_RUN: begin
        if (PIN_WAKE && s_r.joined && s_r.end_opt[asc_pkg::OPT_POLL_WAKE]) begin
          s_nxt.poll_req = 1'b1;
        end
      end
      asc_pkg::FSM_IDLE: s_nxt.fsm = asc_pkg::FSM_IDLE;
      default: s_nxt.fsm = asc_pkg::FSM_IDLE;
    endcase
    // A start request restarts the flow from any state
    if (START) begin
      s_nxt.cyc = 19'h00000;
      s_nxt.per = 16'h0000;
      s_nxt.idx = first_ch[3:0];
      s_nxt.joined = 1'b0;
      s_nxt.coord_up = 1'b0;
      s_nxt.pan_conflict = 1'b0;
      s_nxt.best_ok = 1'b0;
      s_nxt.fail_seen = 1'b0;
      s_nxt.join_req = 1'b0;
      s_nxt.status = asc_pkg::ST_BUSY;
      if (COORD_ROLE) begin
        if (s_r.coord_opt[0]) begin
          s_nxt.fsm = asc_pkg::FSM_ASCAN;
        end else if (s_r.coord_opt[1]) begin
          s_nxt.fsm = asc_pkg::FSM_ESCAN;
        end else begin
          s_nxt.fsm = asc_pkg::FSM_RUN;
          s_nxt.op_chan = OPERATING_CHANNEL;
          s_nxt.coord_up = 1'b1;
          s_nxt.status = asc_pkg::ST_OK;
        end
      end else if (s_r.end_opt[asc_pkg::OPT_AUTO_JOIN] || BEACON_NET) begin
        s_nxt.fsm = asc_pkg::FSM_ASCAN;
      end else begin
        s_nxt.fsm = asc_pkg::FSM_IDLE;
        s_nxt.status = asc_pkg::ST_OK;
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      s_r <= '0;
      s_r.fsm <= asc_pkg::FSM_IDLE;
      s_r.mask <= asc_pkg::MASK_RST;
      s_r.exp <= asc_pkg::EXP_RST;
      s_r.end_opt <= asc_pkg::END_OPT_RST;
      s_r.coord_opt <= asc_pkg::COORD_OPT_RST;
      s_r.status <= asc_pkg::ST_OK;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign RSP = s_r.rsp;
  assign SCAN_ON = (s_r.fsm == asc_pkg::FSM_ASCAN) || (s_r.fsm == asc_pkg::FSM_ESCAN);
  assign SCAN_ENERGY = (s_r.fsm == asc_pkg::FSM_ESCAN);
  assign SCAN_CHANNEL = SCAN_ON ? cur_chan : 8'h00;
  assign OPER_CHANNEL = s_r.op_chan;
  assign PAN_REPLACE = s_r.pan_conflict && COORD_ROLE && s_r.coord_opt[0];
  assign JOIN_REQ = s_r.join_req;
  assign POLL_REQ = s_r.poll_req;
  assign JOINED = s_r.joined;
  assign COORD_UP = s_r.coord_up;
  assign ACCEPT_JOINS = s_r.coord_up && COORD_ROLE
                        && s_r.coord_opt[asc_pkg::OPT_ACCEPT];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_dwell_done;
    cyc_last && per_last && next_ch[4];
  endsequence

  // Restarts and rescans from idle or join wait are not counted; moves inside a scan and reloads between back-to-back scans count
  sequence s_chan_moved;
    SCAN_ON && $past(SCAN_ON) && !$past(START) && $changed(s_r.idx);
  endsequence

  chk_scan_legal: assert property (@(posedge CLK) disable iff (!RESETN)
    SCAN_ON && (mask_eff != 16'h0000) |-> mask_eff[s_r.idx] && (SCAN_CHANNEL == 8'h0B + s_r.idx))
    else $error("scan on a disabled channel");
  chk_hp_range: assert property (@(posedge CLK) disable iff (!RESETN)
    SCAN_ON && HIGH_POWER && (mask_eff != 16'h0000)
    |-> (SCAN_CHANNEL >= 8'h0C) && (SCAN_CHANNEL <= 8'h18))
    else $error("high-power scan outside legal channels");
  chk_exp_reset: assert property (@(posedge CLK)
    !$past(RESETN) && RESETN
    |-> (s_r.exp == 4'h4) && (s_r.end_opt == 4'h0) && (s_r.coord_opt == 3'h0))
    else $error("option registers wrong after reset");
  chk_dwell_count: assert property (@(posedge CLK) disable iff (!RESETN || START)
    s_chan_moved |-> $past(cyc_last) && $past(per_last))
    else $error("channel left before its dwell ended");
  chk_timer_restart: assert property (@(posedge CLK) disable iff (!RESETN)
    SCAN_ON && !START ##0 s_dwell_done |=> (s_r.cyc == 19'h00000) && (s_r.per == 16'h0000))
    else $error("timer not restarted on next channel");
  chk_reserved_zero: assert property (@(posedge CLK) disable iff (!RESETN)
    CMD.rd && (CMD.sel == 3'h2 || CMD.sel == 3'h3) |=> RSP.valid && (RSP.data[15:4] == 12'h000))
    else $error("reserved option bits read nonzero");
  chk_accept_gate: assert property (@(posedge CLK) disable iff (!RESETN)
    ACCEPT_JOINS |-> COORD_ROLE && s_r.coord_opt[2])
    else $error("joins accepted without permission");
  chk_poll_wake: assert property (@(posedge CLK) disable iff (!RESETN)
    (s_r.fsm == asc_pkg::FSM_RUN) && PIN_WAKE && JOINED && !START
    |=> POLL_REQ == $past(s_r.end_opt[3]))
    else $error("poll after pin wake mismatch");
  chk_no_auto: assert property (@(posedge CLK) disable iff (!RESETN)
    START && !COORD_ROLE && !s_r.end_opt[2] && !BEACON_NET |=> !SCAN_ON [*2])
    else $error("join attempted with auto join off");
  chk_busy_code: assert property (@(posedge CLK) disable iff (!RESETN)
    START && !COORD_ROLE && (s_r.end_opt[2] || BEACON_NET) |=> (s_r.status == 8'hFF) && SCAN_ON)
    else $error("busy status missing while joining");

endmodule : asc_core

`default_nettype wire

// ===== bench/asc_radio_model.sv
// Far-side model: a radio reporting beacons and energy, a MAC answering joins.
// Assumes the bench sets the beacon and quiet-channel choices before START.
`default_nettype none

module asc_radio_model (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Scan and join requests
  input wire logic SCAN_ON,
  input wire logic SCAN_ENERGY,
  input wire logic [7:0] SCAN_CHANNEL,
  input wire logic JOIN_REQ,
  // Scenario choices
  input wire logic [7:0] BCN_CHAN,
  input wire logic [3:0] BCN_AT,
  input wire logic BCN_PAN,
  input wire logic [7:0] QUIET_CHAN,
  input wire logic FAIL_JOIN,
  // Reports
  output asc_pkg::asc_beacon_type BEACON,
  output asc_pkg::asc_energy_type ENERGY,
  output logic JOIN_DONE,
  output logic JOIN_FAIL
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [3:0] dwell;
  logic [7:0] last_ch;
  logic [2:0] join_cnt;
  logic hit;

  // ----------------------------------------
  // Reports change on the falling edge only
  // ----------------------------------------
  assign hit = SCAN_ON && !SCAN_ENERGY && SCAN_CHANNEL == BCN_CHAN && dwell == BCN_AT;

  always @(negedge CLK) begin
    if (!RESETN) begin
      dwell <= 4'h0;
      last_ch <= 8'h00;
      join_cnt <= 3'h0;
      BEACON <= '0;
      ENERGY <= '0;
      JOIN_DONE <= 1'b0;
      JOIN_FAIL <= 1'b0;
    end else begin
      // Count rests while idle so every scan started from idle meets its beacon at the same dwell
      dwell <= (SCAN_ON && SCAN_CHANNEL == last_ch) ? dwell + 4'h1 : 4'h0;
      last_ch <= SCAN_CHANNEL;
      // Unqualified fields toggle so a stale value is never trusted
      BEACON.valid <= hit;
      BEACON.pan_match <= hit ? BCN_PAN : ~BEACON.pan_match;
      BEACON.permit <= hit ? 1'b1 : ~BEACON.permit;
      ENERGY.valid <= SCAN_ENERGY;
      ENERGY.level <= !SCAN_ENERGY ? ~ENERGY.level :
                      (SCAN_CHANNEL == QUIET_CHAN) ? 8'h10 : 8'h80;
      // Join answer a few cycles late, as over the air
      join_cnt <= JOIN_REQ ? 3'h3 : (join_cnt != 3'h0) ? join_cnt - 3'h1 : 3'h0;
      JOIN_DONE <= (join_cnt == 3'h1) && !FAIL_JOIN;
      JOIN_FAIL <= (join_cnt == 3'h1) && FAIL_JOIN;
    end
  end

endmodule : asc_radio_model

`default_nettype wire

// ===== bench/asc_core_tb.sv
// Self-checking bench for the association and scan control block.
// Assumes asc_radio_model at the far side and a 4-cycle base period.
`default_nettype none

module asc_core_tb;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int BC = 4;
  logic clk, resetn, coord_role, high_power, beacon_net, start, pin_wake;
  logic join_done, join_fail, scan_on, scan_energy, pan_replace, join_req;
  logic poll_req, joined, coord_up, accept_joins, bcn_pan, fail_join;
  logic [7:0] oper_in, scan_channel, oper_channel, bcn_chan, quiet_chan;
  logic [3:0] bcn_at;
  asc_pkg::asc_cmd_type cmd;
  asc_pkg::asc_rsp_type rsp;
  asc_pkg::asc_beacon_type beacon;
  asc_pkg::asc_energy_type energy;
  int error_cnt = 0;
  int tests_run = 0;

  asc_core #(.BASE_CYCLES(BC)) i_asc_core (
    .CLK(clk), .RESETN(resetn), .CMD(cmd), .RSP(rsp),
    .COORD_ROLE(coord_role), .HIGH_POWER(high_power), .BEACON_NET(beacon_net),
    .OPERATING_CHANNEL(oper_in), .START(start), .PIN_WAKE(pin_wake),
    .JOIN_DONE(join_done), .JOIN_FAIL(join_fail), .BEACON(beacon), .ENERGY(energy),
    .SCAN_ON(scan_on), .SCAN_ENERGY(scan_energy), .SCAN_CHANNEL(scan_channel),
    .OPER_CHANNEL(oper_channel), .PAN_REPLACE(pan_replace), .JOIN_REQ(join_req),
    .POLL_REQ(poll_req), .JOINED(joined), .COORD_UP(coord_up),
    .ACCEPT_JOINS(accept_joins));

  asc_radio_model i_asc_radio_model (
    .CLK(clk), .RESETN(resetn), .SCAN_ON(scan_on), .SCAN_ENERGY(scan_energy),
    .SCAN_CHANNEL(scan_channel), .JOIN_REQ(join_req), .BCN_CHAN(bcn_chan),
    .BCN_AT(bcn_at), .BCN_PAN(bcn_pan), .QUIET_CHAN(quiet_chan), .BEACON(beacon),
    .FAIL_JOIN(fail_join),
    .ENERGY(energy), .JOIN_DONE(join_done), .JOIN_FAIL(join_fail));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] expd, input string what);
    tests_run++;
    if (seen !== expd) begin
      error_cnt++;
      $display("[FAIL] %0t %s: saw %h expected %h", $time, what, seen, expd);
    end
  endtask : check

  task automatic wr(input logic [2:0] sel, input logic [15:0] data);
    @(negedge clk);
    cmd = '{wr: 1'b1, rd: 1'b0, sel: sel, wdata: data};
    @(negedge clk);
    cmd.wr = 1'b0;
  endtask : wr

  task automatic rdchk(input logic [2:0] sel, input logic [15:0] expd, input string what);
    @(negedge clk);
    cmd.rd = 1'b1;
    cmd.sel = sel;
    @(negedge clk);
    cmd.rd = 1'b0;
    check(16'(rsp.valid), 16'h0001, "read answer");
    check(rsp.data, expd, what);
  endtask : rdchk

  task automatic pulse_start;
    @(negedge clk);
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
  endtask : pulse_start

  task automatic pulse_wake;
    @(negedge clk);
    pin_wake = 1'b1;
    @(negedge clk);
    pin_wake = 1'b0;
  endtask : pulse_wake

  task automatic count_on(input logic [7:0] ch, output int n);
    n = 0;
    while (scan_channel === ch && n < 2000) begin
      n++;
      @(negedge clk);
    end
  endtask : count_on

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    rdchk(3'h0, 16'h1FFE, "mask reset");
    rdchk(3'h1, 16'h0004, "exponent reset");
    rdchk(3'h2, 16'h0000, "end options reset");
    rdchk(3'h3, 16'h0000, "coord options reset");
    wr(3'h4, 16'h0055);
    rdchk(3'h4, 16'h0000, "status unwritable");
    rdchk(3'h5, 16'h0000, "unmapped select");
    wr(3'h1, 16'h000F);
    rdchk(3'h1, 16'h000F, "exponent top");
    wr(3'h2, 16'h00FF);
    rdchk(3'h2, 16'h000F, "end options reserved");
    wr(3'h3, 16'h00FF);
    rdchk(3'h3, 16'h0007, "coord options reserved");
    wr(3'h0, 16'hFFFF);
    rdchk(3'h0, 16'hFFFF, "full mask");
    high_power = 1'b1;
    wr(3'h0, 16'hFFFF);
    rdchk(3'h0, 16'h3FFE, "high-power mask");
    high_power = 1'b0;
    $display("regs test done");
  endtask : t_regs

  task automatic t_scan;
    int n;
    wr(3'h0, 16'h0011);
    wr(3'h1, 16'h0001);
    wr(3'h2, 16'h0004);
    pulse_start;
    check(16'(scan_on), 16'h0001, "scan started");
    check(16'(scan_channel), 16'h000B, "first channel");
    count_on(8'h0B, n);
    check(16'(n), 16'(2 * BC), "first dwell");
    check(16'(scan_channel), 16'h000F, "second channel");
    count_on(8'h0F, n);
    check(16'(n), 16'(2 * BC), "second dwell");
    wr(3'h2, 16'h0000);
    pulse_start;
    check(16'(scan_on), 16'h0000, "no join attempt");
    rdchk(3'h4, 16'h0000, "idle status");
    wr(3'h0, 16'h8003);
    wr(3'h2, 16'h0004);
    high_power = 1'b1;
    pulse_start;
    check(16'(scan_channel), 16'h000C, "high-power first channel");
    high_power = 1'b0;
    $display("scan test done");
  endtask : t_scan

  task automatic join_try(input logic [3:0] opts, input logic bn, input logic pm,
                          input logic [7:0] oc, input logic expd, input string what);
    logic seen;
    seen = 1'b0;
    wr(3'h0, 16'h0002);
    wr(3'h1, 16'h0001);
    wr(3'h2, {12'h000, opts});
    beacon_net = bn;
    bcn_pan = pm;
    oper_in = oc;
    pulse_start;
    rdchk(3'h4, 16'h00FF, "status while joining");
    repeat (40) begin
      @(negedge clk);
      seen = seen | (join_req === 1'b1);
    end
    check(16'(seen), 16'(expd), what);
    if (expd) begin
      check(16'(joined), 16'h0001, "joined");
      rdchk(3'h4, 16'h0000, "join complete status");
    end
  endtask : join_try

  task automatic t_joins;
    join_try(4'h5, 1'b0, 1'b0, 8'h0C, 1'b1, "any network");
    join_try(4'h4, 1'b0, 1'b0, 8'h0C, 1'b0, "network mismatch");
    join_try(4'h4, 1'b0, 1'b1, 8'h0D, 1'b0, "channel mismatch");
    join_try(4'h6, 1'b0, 1'b1, 8'h0D, 1'b1, "any channel");
    join_try(4'h0, 1'b1, 1'b1, 8'h0C, 1'b1, "beacon network");
    join_try(4'hD, 1'b0, 1'b1, 8'h0C, 1'b1, "auto join");
    pulse_wake;
    check(16'(poll_req), 16'h0001, "poll after wake");
    wr(3'h2, 16'h0005);
    pulse_wake;
    check(16'(poll_req), 16'h0000, "no poll");
    fail_join = 1'b1;
    pulse_start;
    repeat (12) @(negedge clk);
    check(16'(scan_on), 16'h0001, "rescan after refusal");
    rdchk(3'h4, 16'h000C, "join refused status");
    fail_join = 1'b0;
    repeat (30) @(negedge clk);
    check(16'(joined), 16'h0001, "joined on retry");
    beacon_net = 1'b0;
    $display("join test done");
  endtask : t_joins

  task automatic t_coord;
    int act;
    int nrg;
    logic rep;
    act = 0;
    nrg = 0;
    rep = 1'b0;
    coord_role = 1'b1;
    oper_in = 8'h0E;
    bcn_at = 4'h2;
    wr(3'h0, 16'h0006);
    wr(3'h1, 16'h0000);
    wr(3'h3, 16'h0007);
    pulse_start;
    repeat (60) begin
      act += int'(scan_on === 1'b1 && scan_energy === 1'b0);
      nrg += int'(scan_energy === 1'b1);
      rep = rep | (pan_replace === 1'b1);
      @(negedge clk);
    end
    check(16'(act), 16'(2 * BC), "active scan span");
    check(16'(nrg), 16'(2 * BC), "energy scan span");
    check(16'(rep), 16'h0001, "identifier conflict");
    check(16'(oper_channel), 16'h000D, "quietest channel");
    check(16'(accept_joins), 16'h0001, "joins accepted");
    wr(3'h3, 16'h0000);
    pulse_start;
    check(16'(scan_on), 16'h0000, "no coordinator scan");
    repeat (4) @(negedge clk);
    check(16'(oper_channel), 16'h000E, "configured channel");
    check(16'(accept_joins), 16'h0000, "joins refused");
    check(16'(pan_replace), 16'h0000, "identifier kept");
    check(16'(coord_up), 16'h0001, "coordinator running");
    check(16'(joined), 16'h0000, "no end node join");
    $display("coordinator test done");
  endtask : t_coord

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  // ----------------------------------------
  // Clock, sequence and watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    resetn = 1'b0;
    cmd = '0;
    {coord_role, high_power, beacon_net, start, pin_wake, bcn_pan, fail_join} = 7'h00;
    oper_in = 8'h0C;
    bcn_chan = 8'h0C;
    bcn_at = 4'h5;
    quiet_chan = 8'h0D;
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    t_regs;
    t_scan;
    t_joins;
    t_coord;
    give_verdict;
  end

  // Whole run needs a few hundred cycles; allow far more
  initial begin
    #(20000 * 50);
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    give_verdict;
  end

endmodule : asc_core_tb

`default_nettype wire
